// ---- rtl/adc_cmd_decoder.sv ----
// Command decoder of an eight-channel ADC serial frame interface.
// Assumes a Wishbone master supplying conversion data and a host on the pins.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adc_cmd_decoder #(
    parameter int DATA_PERIOD = adc_cmd_pkg::DATA_PERIOD_CYC,
    parameter logic [15:0] ID_VALUE = 16'h0a08 // Arbitrary identity value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    input wire logic sync_n_i,
    input wire logic rx_check_fail_i,
    output logic data_ready_n_o,
    output logic standby_o,
    output logic locked_o,
    output logic filter_reset_o,
    output logic unsettled_o
);
    spi_word_if w ();

    logic [15:0] regs_r [0:adc_cmd_pkg::NUM_REGS-1];
    logic [23:0] adc_r [0:adc_cmd_pkg::ADC_CHANNELS-1];
    logic [15:0] cmd_r;
    logic [15:0] resp_r;
    logic [6:0] wr_cnt_r;
    logic rd_pend_r;
    logic [5:0] rd_base_r;
    logic [6:0] rd_num_r;
    logic standby_r;
    logic locked_r;
    logic chk_err_r;
    logic data_pend_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic tick;

    function automatic logic [15:0] reg_default(input logic [5:0] a);
        logic [5:0] ofs;
        ofs = a - adc_cmd_pkg::REG_CH0_CFG;
        if (a == adc_cmd_pkg::REG_ID) begin
            return ID_VALUE;
        end else if (a == adc_cmd_pkg::REG_MODE) begin
            return adc_cmd_pkg::MODE_DEFAULT;
        end else if (a == adc_cmd_pkg::REG_CLOCK) begin
            return adc_cmd_pkg::CLOCK_DEFAULT;
        end else if (a == adc_cmd_pkg::REG_CFG) begin
            return adc_cmd_pkg::CFG_DEFAULT;
        end else if (a >= adc_cmd_pkg::REG_CH0_CFG && ofs % adc_cmd_pkg::CH_STRIDE == adc_cmd_pkg::GCAL_MSB_OFS) begin
            return adc_cmd_pkg::GCAL_MSB_DEFAULT;
        end
        return 16'h0000;
    endfunction

    function automatic logic writable(input logic [7:0] a);
        return a >= {2'h0, adc_cmd_pkg::REG_FIRST_RW} && a <= {2'h0, adc_cmd_pkg::REG_LAST};
    endfunction

    function automatic adc_cmd_pkg::cmd_kind_t decode(input logic [15:0] c, input logic frozen);
        adc_cmd_pkg::cmd_kind_t k;
        if (c[15:13] == adc_cmd_pkg::PFX_READ) begin
            k = adc_cmd_pkg::K_READ;
        end else if (c[15:13] == adc_cmd_pkg::PFX_WRITE) begin
            k = adc_cmd_pkg::K_WRITE;
        end else if (c == adc_cmd_pkg::CMD_RESET) begin
            k = adc_cmd_pkg::K_RESET;
        end else if (c == adc_cmd_pkg::CMD_STANDBY) begin
            k = adc_cmd_pkg::K_STANDBY;
        end else if (c == adc_cmd_pkg::CMD_RESUME) begin
            k = adc_cmd_pkg::K_RESUME;
        end else if (c == adc_cmd_pkg::CMD_FREEZE) begin
            k = adc_cmd_pkg::K_FREEZE;
        end else if (c == adc_cmd_pkg::CMD_THAW || c == adc_cmd_pkg::CMD_THAW_ALT) begin
            k = adc_cmd_pkg::K_THAW;
        end else begin
            k = adc_cmd_pkg::K_NOOP;
        end
        if (frozen && k != adc_cmd_pkg::K_READ && k != adc_cmd_pkg::K_THAW) begin
            k = adc_cmd_pkg::K_NOOP;
        end
        return k;
    endfunction

    wire [15:0] mode_w = regs_r[adc_cmd_pkg::REG_MODE];
    wire [1:0] wlen_w = mode_w[adc_cmd_pkg::MODE_WLEN_LSB +: 2];
    wire [15:0] status_w = {locked_r, 2'b00, chk_err_r, mode_w[11:8], {8{data_pend_r}}};

    function automatic logic [15:0] reg_view(input logic [7:0] a);
        if (a == {2'h0, adc_cmd_pkg::REG_STATUS}) begin
            return status_w;
        end else if (a <= {2'h0, adc_cmd_pkg::REG_LAST}) begin
            return regs_r[a[5:0]];
        end
        return 16'h0000;
    endfunction

    spi_word_shifter u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .din_i(din_i),
        .dout_o(dout_o),
        .dout_oe_o(dout_oe_o),
        .w(w.shifter)
    );

    sync_pulse_detect #(
        .DATA_PERIOD(DATA_PERIOD)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sync_n_i(sync_n_i),
        .gc_en_i(regs_r[adc_cmd_pkg::REG_CFG][adc_cmd_pkg::CFG_GC_EN_BIT]),
        .filter_reset_o(filter_reset_o),
        .tick_o(tick),
        .unsettled_o(unsettled_o)
    );

    // Command field decode
    wire cmd_now = w.word_done && w.done_idx == 8'h00;
    wire [5:0] cmd_addr = cmd_r[12:7];
    wire [6:0] cmd_num = cmd_r[6:0];
    wire adc_cmd_pkg::cmd_kind_t kind = decode(cmd_r, locked_r);
    wire frame_full = w.word_idx >= adc_cmd_pkg::FRAME_WORDS;

    // Register write path, one word at a time
    wire [7:0] wr_ofs = w.done_idx - 8'h01;
    wire [7:0] wr_addr = {2'h0, cmd_addr} + wr_ofs;
    wire wr_hit = w.word_done && w.done_idx != 8'h00 && kind == adc_cmd_pkg::K_WRITE &&
                  wr_ofs <= {1'b0, cmd_num};
    wire wr_ok = wr_hit && writable(wr_addr);
    wire dev_reset = w.frame_end && kind == adc_cmd_pkg::K_RESET && frame_full;

    // Outgoing word for the slot now being loaded
    wire [7:0] out_ofs = w.word_idx - 8'h01;
    wire [7:0] rd_addr = {2'h0, rd_base_r} + out_ofs;
    wire in_stream = rd_pend_r && out_ofs <= {1'b0, rd_num_r};
    wire [23:0] adc_word = adc_r[out_ofs[2:0]];
    wire [31:0] adc_aligned = (wlen_w == adc_cmd_pkg::WLEN_32_SIGN) ?
                              {{8{adc_word[23]}}, adc_word} : {adc_word, 8'h00};
    wire adc_slot = !rd_pend_r && w.word_idx != 8'h00 && w.word_idx <= adc_cmd_pkg::ADC_LAST_WORD;

    assign w.out_word = (w.word_idx == 8'h00) ? {resp_r, 16'h0000} :
                        in_stream ? {reg_view(rd_addr), 16'h0000} :
                        adc_slot ? adc_aligned : 32'h0;
    assign w.wlen_bits = (wlen_w == adc_cmd_pkg::WLEN_16) ? 6'h10 :
                         (wlen_w == adc_cmd_pkg::WLEN_24) ? 6'h18 : 6'h20;

    // Device register file
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_reset) begin
            for (int i = 0; i < adc_cmd_pkg::NUM_REGS; i++) begin
                regs_r[i] <= reg_default(6'(i));
            end
        end else if (wr_ok) begin
            regs_r[wr_addr[5:0]] <= w.word_in;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || w.frame_start) begin
            cmd_r <= adc_cmd_pkg::CMD_NOOP;
            wr_cnt_r <= 7'h00;
        end else begin
            if (cmd_now) begin
                cmd_r <= w.word_in;
            end
            if (wr_ok) begin
                wr_cnt_r <= wr_cnt_r + 7'h01;
            end
        end
    end

    // End-of-frame latching of responses and modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_r <= adc_cmd_pkg::CMD_NOOP;
            rd_pend_r <= 1'b0;
            rd_base_r <= 6'h00;
            rd_num_r <= 7'h00;
            standby_r <= 1'b0;
            locked_r <= 1'b0;
        end else if (w.frame_end) begin
            rd_pend_r <= kind == adc_cmd_pkg::K_READ && cmd_num != 7'h00;
            rd_base_r <= cmd_addr;
            rd_num_r <= cmd_num;
            case (kind)
                adc_cmd_pkg::K_RESET: begin
                    // A clipped reset frame is answered but changes nothing
                    resp_r <= frame_full ? adc_cmd_pkg::RESP_RESET_DONE : adc_cmd_pkg::RESP_RESET_SHORT;
                    if (frame_full) begin
                        standby_r <= 1'b0;
                        locked_r <= 1'b0;
                    end
                end
                adc_cmd_pkg::K_STANDBY: begin
                    resp_r <= cmd_r;
                    standby_r <= 1'b1;
                end
                adc_cmd_pkg::K_RESUME: begin
                    resp_r <= cmd_r;
                    standby_r <= 1'b0;
                end
                adc_cmd_pkg::K_FREEZE: begin
                    resp_r <= cmd_r;
                    locked_r <= 1'b1;
                end
                adc_cmd_pkg::K_THAW: begin
                    resp_r <= cmd_r;
                    locked_r <= 1'b0;
                end
                adc_cmd_pkg::K_READ: begin
                    resp_r <= (cmd_num == 7'h00) ? reg_view({2'h0, cmd_addr}) :
                              {adc_cmd_pkg::PFX_READ_ACK, cmd_addr, cmd_num};
                end
                adc_cmd_pkg::K_WRITE: begin
                    resp_r <= {adc_cmd_pkg::PFX_WRITE_ACK, cmd_addr, wr_cnt_r - 7'h01};
                end
                default: begin
                    resp_r <= status_w;
                end
            endcase
        end
    end

    // Sticky input-check error: a new failure beats the clear on status read
    wire chk_clear = w.frame_end && kind == adc_cmd_pkg::K_NOOP;
    wire data_taken = w.frame_end && !rd_pend_r && w.word_idx > adc_cmd_pkg::CHECK_WORD;

    always_ff @(posedge clk_i) begin
        if (rst_i || dev_reset) begin
            chk_err_r <= 1'b0;
        end else if (rx_check_fail_i) begin
            chk_err_r <= 1'b1;
        end else if (chk_clear) begin
            chk_err_r <= 1'b0;
        end
    end

    // Wishbone slave: conversion data in, block state out
    wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wb_wr = wb_req & wb_we_i;
    wire wb_in_ch = wb_adr_i >= adc_cmd_pkg::WB_CH0 && wb_adr_i <= adc_cmd_pkg::WB_CH_LAST &&
                    wb_adr_i[1:0] == 2'h0;
    wire [2:0] wb_ch = 3'(wb_adr_i[7:2] - adc_cmd_pkg::WB_CH0[7:2]);
    wire new_data = wb_wr && wb_adr_i == adc_cmd_pkg::WB_DATA_VALID;
    wire [31:0] wb_rd_w = (wb_adr_i == adc_cmd_pkg::WB_STATE) ?
                          {26'h0, unsettled_o, chk_err_r, data_pend_r, rd_pend_r, locked_r, standby_r} :
                          wb_in_ch ? {8'h00, adc_r[wb_ch]} :
                          (wb_adr_i == adc_cmd_pkg::WB_DATA_VALID) ? {31'h0, data_pend_r} : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < adc_cmd_pkg::ADC_CHANNELS; i++) begin
                adc_r[i] <= 24'h0;
            end
        end else if (wb_wr && wb_in_ch) begin
            for (int b = 0; b < 3; b++) begin
                if (wb_sel_i[b]) begin
                    adc_r[wb_ch][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // New data beats both a finished readout and a filter restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_pend_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            if (new_data) begin
                data_pend_r <= 1'b1;
            end else if (data_taken || filter_reset_o) begin
                data_pend_r <= 1'b0;
            end
            ack_r <= wb_req;
            if (wb_req) begin
                dat_r <= wb_rd_w;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign data_ready_n_o = ~data_pend_r;
    assign standby_o = standby_r;
    assign locked_o = locked_r;
endmodule
`default_nettype wire

// ---- rtl/adc_cmd_pkg.sv ----
// Constants shared by the ADC serial command decoder and its helpers.
// Assumes a 250 MHz system clock that oversamples the serial link.
package adc_cmd_pkg;

    // Command words and fixed responses
    localparam logic [15:0] CMD_NOOP = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0011;
    localparam logic [15:0] CMD_STANDBY = 16'h0022;
    localparam logic [15:0] CMD_RESUME = 16'h0033;
    localparam logic [15:0] CMD_FREEZE = 16'h0555;
    localparam logic [15:0] CMD_THAW = 16'h0655;
    localparam logic [15:0] CMD_THAW_ALT = 16'h0666;
    localparam logic [15:0] RESP_RESET_DONE = 16'hff28;
    localparam logic [15:0] RESP_RESET_SHORT = 16'h0011;
    localparam logic [2:0] PFX_READ = 3'h5;
    localparam logic [2:0] PFX_WRITE = 3'h3;
    localparam logic [2:0] PFX_READ_ACK = 3'h7;
    localparam logic [2:0] PFX_WRITE_ACK = 3'h2;

    // Frame layout
    localparam logic [7:0] FRAME_WORDS = 8'h0a;
    localparam logic [7:0] ADC_LAST_WORD = 8'h08;
    localparam logic [7:0] CHECK_WORD = 8'h09;
    localparam int ADC_CHANNELS = 8;

    // Device register map
    localparam int NUM_REGS = 49;
    localparam logic [5:0] REG_ID = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h01;
    localparam logic [5:0] REG_MODE = 6'h02;
    localparam logic [5:0] REG_CLOCK = 6'h03;
    localparam logic [5:0] REG_CFG = 6'h06;
    localparam logic [5:0] REG_FIRST_RW = 6'h02;
    localparam logic [5:0] REG_LAST = 6'h30;
    localparam logic [5:0] REG_CH0_CFG = 6'h09;
    localparam logic [5:0] CH_STRIDE = 6'h05;
    localparam logic [5:0] GCAL_MSB_OFS = 6'h03;
    localparam logic [15:0] MODE_DEFAULT = 16'h0510;
    localparam logic [15:0] CLOCK_DEFAULT = 16'hff0e;
    localparam logic [15:0] CFG_DEFAULT = 16'h0600;
    localparam logic [15:0] GCAL_MSB_DEFAULT = 16'h8000;
    localparam int MODE_WLEN_LSB = 8;
    localparam int CFG_GC_EN_BIT = 8;
    localparam logic [1:0] WLEN_16 = 2'h0;
    localparam logic [1:0] WLEN_24 = 2'h1;
    localparam logic [1:0] WLEN_32_SIGN = 2'h3;

    // Wishbone map of the system side
    localparam logic [7:0] WB_STATE = 8'h00;
    localparam logic [7:0] WB_CH0 = 8'h04;
    localparam logic [7:0] WB_CH_LAST = 8'h20;
    localparam logic [7:0] WB_DATA_VALID = 8'h24;

    // Timing
    localparam int CLK_MHZ = 250;
    localparam int SYNC_MIN_NS = 125;
    localparam int SYNC_MAX_NS = 2000;
    localparam int SYNC_MIN_CYC = (SYNC_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_MAX_CYC = (SYNC_MAX_NS * CLK_MHZ) / 1000;
    localparam int DATA_PERIOD_CYC = 62500;
    localparam logic [1:0] SETTLE_CONVS = 2'h3;

    typedef enum logic [2:0] {
        K_NOOP = 3'b000,
        K_RESET = 3'b001,
        K_STANDBY = 3'b010,
        K_RESUME = 3'b011,
        K_FREEZE = 3'b100,
        K_THAW = 3'b101,
        K_READ = 3'b110,
        K_WRITE = 3'b111
    } cmd_kind_t;

endpackage

// ---- rtl/spi_word_if.sv ----
// Word-level link between the serial shifter and the command core.
// Both ends run on clk_i; pulses last one cycle.
`timescale 1ns/100ps
`default_nettype none
interface spi_word_if;
    logic frame_start;
    logic frame_end;
    logic word_done;
    logic [15:0] word_in;
    logic [7:0] done_idx;
    logic [7:0] word_idx;
    logic [31:0] out_word;
    logic [5:0] wlen_bits;
    modport shifter(output frame_start, frame_end, word_done, word_in, done_idx, word_idx,
                    input out_word, wlen_bits);
    modport core(input frame_start, frame_end, word_done, word_in, done_idx, word_idx,
                 output out_word, wlen_bits);
endinterface
`default_nettype wire

// ---- rtl/spi_word_shifter.sv ----
// Oversampling serial shifter: mode 1 (out on rising, in on falling).
// Assumes sclk far slower than clk_i; pins are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module spi_word_shifter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    spi_word_if.shifter w
);
    logic [2:0] sclk_s_r;
    logic [2:0] cs_s_r;
    logic [1:0] din_s_r;
    logic [31:0] in_sr_r;
    logic [31:0] out_sr_r;
    logic [5:0] bit_cnt_r;
    logic [7:0] idx_r;
    logic done_r;
    logic [15:0] word_r;
    logic [7:0] done_idx_r;
    logic start_r;
    logic end_r;

    wire active = ~cs_s_r[1];
    wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
    wire cs_fall = ~cs_s_r[1] & cs_s_r[2];
    wire cs_rise = cs_s_r[1] & ~cs_s_r[2];
    wire [31:0] full_w = {in_sr_r[30:0], din_s_r[1]};
    wire [5:0] bit_nxt = bit_cnt_r + 6'h01;
    wire word_end = active & sclk_fall & (bit_nxt == w.wlen_bits);
    // Only the top 16 bits of a word carry meaning; the rest is padding
    wire [15:0] top16 = (w.wlen_bits == 6'h10) ? full_w[15:0] :
                        (w.wlen_bits == 6'h18) ? full_w[23:8] : full_w[31:16];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_s_r <= 3'h0;
            cs_s_r <= 3'h7;
            din_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], sclk_i};
            cs_s_r <= {cs_s_r[1:0], cs_n_i};
            din_s_r <= {din_s_r[0], din_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || cs_fall) begin
            bit_cnt_r <= 6'h00;
            idx_r <= 8'h00;
            in_sr_r <= 32'h0;
            out_sr_r <= 32'h0;
        end else if (active) begin
            if (sclk_rise) begin
                out_sr_r <= (bit_cnt_r == 6'h00) ? w.out_word : {out_sr_r[30:0], 1'b0};
            end
            if (sclk_fall) begin
                in_sr_r <= full_w;
                bit_cnt_r <= word_end ? 6'h00 : bit_nxt;
                if (word_end && idx_r != 8'hff) begin
                    idx_r <= idx_r + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
            word_r <= 16'h0;
            done_idx_r <= 8'h00;
            start_r <= 1'b0;
            end_r <= 1'b0;
        end else begin
            done_r <= word_end;
            if (word_end) begin
                word_r <= top16;
                done_idx_r <= idx_r;
            end
            start_r <= cs_fall;
            end_r <= cs_rise;
        end
    end

    assign w.frame_start = start_r;
    assign w.frame_end = end_r;
    assign w.word_done = done_r;
    assign w.word_in = word_r;
    assign w.done_idx = done_idx_r;
    assign w.word_idx = idx_r;
    assign dout_o = active & out_sr_r[31];
    assign dout_oe_o = active;
endmodule
`default_nettype wire

// ---- rtl/sync_pulse_detect.sv ----
// Sync pin pulse qualifier, data-rate timebase and settling tracker.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module sync_pulse_detect #(
    parameter int DATA_PERIOD = adc_cmd_pkg::DATA_PERIOD_CYC,
    parameter int MIN_CYC = adc_cmd_pkg::SYNC_MIN_CYC,
    parameter int MAX_CYC = adc_cmd_pkg::SYNC_MAX_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sync_n_i,
    input wire logic gc_en_i,
    output logic filter_reset_o,
    output logic tick_o,
    output logic unsettled_o
);
    logic [2:0] pin_s_r;
    logic [31:0] phase_r;
    logic [15:0] width_r;
    logic aligned_r;
    logic fire_r;
    logic [1:0] settle_r;

    wire fall = ~pin_s_r[1] & pin_s_r[2];
    wire rise = pin_s_r[1] & ~pin_s_r[2];
    wire at_end = (phase_r >= 32'(DATA_PERIOD - 1));
    wire good_width = (width_r > 16'(MIN_CYC)) && (width_r < 16'(MAX_CYC));
    // Misaligned pulses of valid width restart filters; with global chop, aligned pulses of valid width restart too
    wire fire = rise & good_width & (~aligned_r | gc_en_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s_r <= 3'h7;
            phase_r <= 32'h0;
            width_r <= 16'h0;
            aligned_r <= 1'b1;
            fire_r <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            pin_s_r <= {pin_s_r[1:0], sync_n_i};
            fire_r <= fire;
            if (fire) begin
                // Timebase restarts as if the falling edge were phase zero
                phase_r <= 32'(width_r);
                settle_r <= adc_cmd_pkg::SETTLE_CONVS;
            end else begin
                phase_r <= at_end ? 32'h0 : phase_r + 32'h1;
                if (at_end && settle_r != 2'h0) begin
                    settle_r <= settle_r - 2'h1;
                end
            end
            if (fall) begin
                aligned_r <= (phase_r == 32'h0);
                width_r <= 16'h0;
            end else if (~pin_s_r[1] && width_r != 16'hffff) begin
                width_r <= width_r + 16'h1;
            end
        end
    end

    assign filter_reset_o = fire_r;
    assign tick_o = at_end;
    assign unsettled_o = (settle_r != 2'h0);
endmodule
`default_nettype wire

// ---- tb/adc_cmd_decoder_properties.sv ----
// Port checks of the command decoder.
// Bound onto adc_cmd_decoder below.
`timescale 1ns/100ps
`default_nettype none
module adc_cmd_decoder_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cs_n_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic standby_o,
    input wire logic locked_o,
    input wire logic filter_reset_o,
    input wire logic unsettled_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Long enough for the pin synchronisers
    sequence s_idle;
        cs_n_i [*6];
    endsequence
    AST_ACK: assert property (s_req |=> wb_ack_o) else $error("late ack");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    AST_OE: assert property (s_idle |-> !dout_oe_o) else $error("oe while idle");
    AST_DOUT: assert property (!dout_oe_o |-> !dout_o) else $error("dout not low");
    AST_STANDBY: assert property ($changed(standby_o) |-> s_idle) else $error("standby mid frame");
    AST_LOCK: assert property ($changed(locked_o) |-> s_idle) else $error("lock mid frame");
    AST_RESTART: assert property (filter_reset_o |=> !filter_reset_o) else $error("long restart");
    AST_SETTLE: assert property (filter_reset_o |-> ##2 unsettled_o [*8]) else $error("no settle");
endmodule
bind adc_cmd_decoder adc_cmd_decoder_properties chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .standby_o(standby_o), .locked_o(locked_o), .filter_reset_o(filter_reset_o), .unsettled_o(unsettled_o));
`default_nettype wire

// ---- tb/spi_host_model.sv ----
// Host side of the serial link: 24-bit words, mode 1.
// Runs on its own ns timing, unrelated to clk_i.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    input wire logic dout_i,
    output logic sclk_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic din_o = 1'b0,
    output logic sync_n_o = 1'b1
);
    logic [15:0] rx [0:15];
    logic [23:0] w;
    // Caller sets full length for reset and pending data
    task automatic frame(input logic [15:0] cmd, input logic [15:0] wd, input int words);
        #1.3;
        cs_n_o = 1'b0;
        #80;
        for (int i = 0; i < words; i++) begin
            w = {(i == 0) ? cmd : (i == 1) ? wd : 16'h0000, 8'h00};
            for (int b = 23; b >= 0; b--) begin
                sclk_o = 1'b1;
                din_o = w[b];
                #80;
                sclk_o = 1'b0;
                if (b > 7) rx[i][b - 8] = dout_i;
                #80;
            end
        end
        cs_n_o = 1'b1;
        din_o = ~din_o;
        #2000; // Gap also covers settling after reset
    endtask
    task automatic sync_pulse();
        sync_n_o = 1'b0;
        #256; // 64 clocks wide
        sync_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/adc_spi_command_decoder_bench.sv ----
// Self-checking bench of the command decoder.
// Host model drives the link; bench drives Wishbone.
`timescale 1ns/100ps
`default_nettype none
module adc_spi_command_decoder_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] q, rd;
    logic ack, dout, oe, sclk, cs_n, din, sync_n, rdy_n, sb, lk, fr, uns;
    logic chkf = 1'b0;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    // cmd, write word, answer, words, standby after
    localparam logic [55:0] ROWS [0:18] = '{
        56'h0000_0000_0500_10, 56'h0022_0000_0022_11, 56'h0022_0000_0022_11,
        56'h0033_0000_0033_10, 56'h0033_0000_0033_10, 56'h1234_0000_0500_10,
        56'h0555_0000_0555_10, 56'h0022_0000_8500_10, 56'h0655_0000_0655_10,
        56'h0555_0000_0555_10, 56'h0666_0000_0666_10, 56'ha100_0000_0510_10,
        56'h6300_0602_4300_20, 56'h6000_1234_407f_20, 56'h0011_0000_0011_10,
        56'ha300_0000_0602_10, 56'h0011_0000_ff28_a0, 56'ha300_0000_0600_10,
        56'ha101_0000_e101_10};
    spi_host_model host (.dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .sync_n_o(sync_n));
    adc_cmd_decoder #(.DATA_PERIOD(64)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(q), .wb_ack_o(ack),
        .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(oe), .sync_n_i(sync_n),
        .rx_check_fail_i(chkf), .data_ready_n_o(rdy_n), .standby_o(sb), .locked_o(lk),
        .filter_reset_o(fr), .unsettled_o(uns));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = q;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic print_verdict();
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 19; i++) begin
            host.frame(ROWS[i][55:40], ROWS[i][39:24], int'(ROWS[i][7:4]));
            if (i > 0) chk(host.rx[0], ROWS[i - 1][23:8]);
            chk({15'h0000, sb}, {12'h000, ROWS[i][3:0]});
        end
        wb(1'b1, 8'h24, 32'h00000001);
        wb(1'b1, 8'h0c, 32'h00abcdef);
        wb(1'b0, 8'h24, 32'h00000000);
        chk(rd[15:0], 16'h0001);
        chk({15'h0000, rdy_n}, 16'h0000);
        wb(1'b0, 8'h28, 32'h00000000);
        chk(rd[15:0], 16'h0000);
        chkf <= 1'b1;
        @(posedge clk_i);
        chkf <= 1'b0;
        host.frame(16'h0000, 16'h0000, 10);
        chk(host.rx[0], 16'he101);
        chk(host.rx[1], 16'h0510);
        chk(host.rx[2], 16'hff0e);
        chk(host.rx[3], 16'h0000);
        // Global chop on, so the sync pulse restarts whatever the phase
        host.frame(16'h6300, 16'h0700, 10);
        chk(host.rx[0], 16'h15ff);
        chk(host.rx[3], 16'habcd);
        chk({15'h0000, rdy_n}, 16'h0001);
        host.sync_pulse();
        repeat (10) @(posedge clk_i);
        chk({15'h0000, uns}, 16'h0001);
        repeat (250) @(posedge clk_i);
        chk({15'h0000, uns}, 16'h0000);
        host.frame(16'h0022, 16'h0000, 1);
        chk(host.rx[0], 16'h4300);
        chk({15'h0000, sb}, 16'h0001);
        wb(1'b1, 8'h24, 32'h00000001);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({12'h000, sb, lk, uns, rdy_n}, 16'h0001);
        print_verdict();
    end
endmodule
`default_nettype wire
